// >>> pkg/bsq_pkg.sv
// Constants, types and register map of the brown-out and start-up reset
// sequencer. Assumes one 50 MHz system clock and static configuration.
package bsq_pkg;

    // System clock period
    localparam int CLK_NS = 20;

    // Register offsets and field positions
    localparam logic [1:0] CTRL_OFS = 2'h0;
    localparam logic [1:0] STAT_OFS = 2'h1;
    localparam int SOFT_BOR_BIT = 6;
    localparam int POWERON_FLAG_BIT = 1;
    localparam int BROWNOUT_FLAG_BIT = 0;
    localparam int STAT_BOR_BIT = 3;
    localparam int STAT_LOW_BIT = 4;
    localparam int STAT_RST_BIT = 5;
    localparam int STAT_WAKE_BIT = 6;

    // Reset values of the control fields
    localparam logic SOFT_BOR_RST = 1'b1;
    localparam logic POWERON_FLAG_RST = 1'b0;
    localparam logic BROWNOUT_FLAG_RST = 1'b0;

    // Brown-out enable settings
    localparam logic [1:0] BOR_OFF = 2'h0;
    localparam logic [1:0] BOR_SOFT = 2'h1;
    localparam logic [1:0] BOR_NO_SLEEP = 2'h2;
    localparam logic [1:0] BOR_ON = 2'h3;

    // Timer widths and counts
    localparam int TMR_W = 17;
    localparam int LOW_W = 8;
    localparam int POWERUP_TIMER_TICKS = 2048;
    localparam int OST_TICKS = 1024;
    localparam int BOR_MIN_NS = 2000;
    localparam int BOR_MIN_CYC = (BOR_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int PLL_LOCK_NS = 2000000;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_NS - 1) / CLK_NS;

    // Oscillator modes
    typedef enum logic [2:0] {
        OSC_LP = 3'h0,
        OSC_XT = 3'h1,
        OSC_HS = 3'h2,
        OSC_HS_CRYSTAL_PLL_MODE = 3'h3,
        OSC_EC = 3'h4,
        OSC_RC = 3'h5,
        OSC_INT = 3'h6
    } bsq_osc_t;

    // Sequencer states, Gray coded along the start-up path
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_POWERUP_TIMER = 3'h1,
        ST_OST = 3'h3,
        ST_PLL = 3'h2,
        ST_DONE = 3'h6,
        ST_BOR = 3'h4
    } bsq_state_t;

    // Configuration fuses as one bundle
    typedef struct packed {
        logic [1:0] bor_enable_config;
        logic [1:0] bor_voltage_select;
        logic powerup_timer_disable_n;
        bsq_osc_t osc_mode;
    } bsq_cfg_t;

endpackage : bsq_pkg

// >>> src/bsq_timer.sv
// Down counter shared by the start-up time-outs.
// Assumes load and tick come from logic on the same clock.
`timescale 1ns/1ps
module bsq_timer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [bsq_pkg::TMR_W-1:0] i_value,
    input wire logic i_tick,
    output logic o_done
);
    logic [bsq_pkg::TMR_W-1:0] cnt_r;

    // Load wins over a tick; count stops at zero
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_r <= '0;
        end else if (i_load) begin
            cnt_r <= i_value;
        end else if (i_tick && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Done once the count has run down; kept free of the load, which the
    // sequencer decodes from done, so no combinational loop forms
    assign o_done = cnt_r == '0;
endmodule : bsq_timer

// >>> src/bsq_sequencer.sv
// Brown-out and start-up reset sequencer: brown-out control, power-up
// timer, oscillator start-up timer, PLL lock time-out and core reset.
// Assumes comparator, pins and slow clocks are asynchronous to I_CLK and
// that the configuration bundle is static after power-up.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
module bsq_sequencer #(
    parameter int P_PLL_LOCK_CYC = bsq_pkg::PLL_LOCK_CYC
) (
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire bsq_pkg::bsq_cfg_t I_CFG,
    input wire logic I_POR_PULSE,
    input wire logic I_SUPPLY_LOW,
    input wire logic I_MASTER_CLEAR_N,
    input wire logic I_LFRC_CLK,
    input wire logic I_OSC_IN,
    input wire logic I_SLEEP,
    input wire logic I_PM_EXIT,
    input wire logic [1:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [7:0] O_RDATA,
    output logic O_CORE_RST,
    output logic O_EXEC_HOLD,
    output logic O_BOR_ACTIVE,
    output logic [1:0] O_BOR_VSEL
);
    localparam logic [bsq_pkg::TMR_W-1:0] POWERUP_TIMER_VAL =
        bsq_pkg::TMR_W'(bsq_pkg::POWERUP_TIMER_TICKS);
    localparam logic [bsq_pkg::TMR_W-1:0] OST_VAL =
        bsq_pkg::TMR_W'(bsq_pkg::OST_TICKS);
    localparam logic [bsq_pkg::TMR_W-1:0] PLL_VAL =
        bsq_pkg::TMR_W'(P_PLL_LOCK_CYC);
    localparam logic [bsq_pkg::LOW_W-1:0] LOW_MIN =
        bsq_pkg::LOW_W'(bsq_pkg::BOR_MIN_CYC);

    // Crystal modes that need the oscillator start-up timer
    function automatic logic is_crystal(input bsq_pkg::bsq_osc_t m);
        return m == bsq_pkg::OSC_LP || m == bsq_pkg::OSC_XT ||
            m == bsq_pkg::OSC_HS || m == bsq_pkg::OSC_HS_CRYSTAL_PLL_MODE;
    endfunction : is_crystal

    // First timed phase after the pulse or a brown-out ends
    function automatic bsq_pkg::bsq_state_t first_phase(
        input logic powerup_timer_en, input logic xtal);
        if (powerup_timer_en) begin
            return bsq_pkg::ST_POWERUP_TIMER;
        end else if (xtal) begin
            return bsq_pkg::ST_OST;
        end
        return bsq_pkg::ST_DONE;
    endfunction : first_phase

    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic lfrc_d_r;
    logic osc_d_r;
    logic por_s;
    logic low_s;
    logic master_clear_pin_n_s;
    logic lfrc_rise;
    logic osc_rise;
    logic soft_bor_r;
    logic poweron_flag_r;
    logic brownout_flag_r;
    logic [bsq_pkg::LOW_W-1:0] low_cnt_r;
    logic bor_en;
    logic bor_trip;
    logic powerup_timer_en;
    logic xtal;
    logic pll_mode;
    logic soft_mode;
    bsq_pkg::bsq_state_t state_r;
    bsq_pkg::bsq_state_t state_nxt;
    logic wake_r;
    logic tmr_load;
    logic tmr_tick;
    logic tmr_done;
    logic [bsq_pkg::TMR_W-1:0] tmr_value;
    logic core_rst_nxt;

    // Two-stage synchronisers for pins, comparator and slow clocks
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            sync1_r <= 5'h01;
            sync2_r <= 5'h01;
        end else begin
            sync1_r <= {I_OSC_IN, I_LFRC_CLK, I_MASTER_CLEAR_N,
                I_SUPPLY_LOW, I_POR_PULSE};
            sync2_r <= sync1_r;
        end
    end

    // Edge detectors on the synchronised slow clocks
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            lfrc_d_r <= 1'b0;
            osc_d_r <= 1'b0;
        end else begin
            lfrc_d_r <= sync2_r[3];
            osc_d_r <= sync2_r[4];
        end
    end

    assign por_s = sync2_r[0];
    assign low_s = sync2_r[1];
    assign master_clear_pin_n_s = sync2_r[2];
    assign lfrc_rise = sync2_r[3] && !lfrc_d_r;
    assign osc_rise = sync2_r[4] && !osc_d_r;

    // Configuration decode
    assign soft_mode = I_CFG.bor_enable_config == bsq_pkg::BOR_SOFT;
    assign powerup_timer_en = !I_CFG.powerup_timer_disable_n;
    assign xtal = is_crystal(I_CFG.osc_mode);
    assign pll_mode = I_CFG.osc_mode == bsq_pkg::OSC_HS_CRYSTAL_PLL_MODE;

    // Brown-out enable per fuse setting
    always_comb begin
        unique case (I_CFG.bor_enable_config)
            bsq_pkg::BOR_OFF: bor_en = 1'b0;
            bsq_pkg::BOR_SOFT: bor_en = soft_bor_r;
            bsq_pkg::BOR_NO_SLEEP: bor_en = !I_SLEEP;
            bsq_pkg::BOR_ON: bor_en = 1'b1;
        endcase
    end

    // Low-supply duration count; trips past the minimum time
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            low_cnt_r <= '0;
        end else if (!(low_s && bor_en)) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != LOW_MIN) begin
            low_cnt_r <= low_cnt_r + 1'b1;
        end
    end

    assign bor_trip = low_s && bor_en && low_cnt_r == LOW_MIN;

    // Next state of the reset sequence
    always_comb begin
        state_nxt = state_r;
        if (por_s) begin
            state_nxt = bsq_pkg::ST_POR;
        end else if (bor_trip && state_r != bsq_pkg::ST_BOR) begin
            state_nxt = bsq_pkg::ST_BOR;
        end else begin
            unique case (state_r)
                bsq_pkg::ST_POR: begin
                    state_nxt = first_phase(powerup_timer_en, xtal);
                end
                bsq_pkg::ST_BOR: begin
                    if (!low_s) begin
                        state_nxt = first_phase(powerup_timer_en, xtal);
                    end
                end
                bsq_pkg::ST_POWERUP_TIMER: begin
                    if (tmr_done) begin
                        state_nxt = xtal ? bsq_pkg::ST_OST
                            : bsq_pkg::ST_DONE;
                    end
                end
                bsq_pkg::ST_OST: begin
                    if (tmr_done) begin
                        state_nxt = pll_mode ? bsq_pkg::ST_PLL
                            : bsq_pkg::ST_DONE;
                    end
                end
                bsq_pkg::ST_PLL: begin
                    if (tmr_done) begin
                        state_nxt = bsq_pkg::ST_DONE;
                    end
                end
                bsq_pkg::ST_DONE: begin
                    if (I_PM_EXIT && xtal) begin
                        state_nxt = bsq_pkg::ST_OST;
                    end
                end
                default: state_nxt = bsq_pkg::ST_POR;
            endcase
        end
    end

    // Sequence state
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= bsq_pkg::ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Wake marks an oscillator wait that holds execution, not reset
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            wake_r <= 1'b0;
        end else if (state_nxt == bsq_pkg::ST_DONE ||
            state_nxt == bsq_pkg::ST_POR || state_nxt == bsq_pkg::ST_BOR) begin
            wake_r <= 1'b0;
        end else if (state_r == bsq_pkg::ST_DONE &&
            state_nxt == bsq_pkg::ST_OST) begin
            wake_r <= 1'b1;
        end
    end

    // Timer reloads on every phase change, ticking from the phase source
    assign tmr_load = state_nxt != state_r;
    always_comb begin
        tmr_value = '0;
        tmr_tick = 1'b0;
        unique case (state_nxt)
            bsq_pkg::ST_POWERUP_TIMER: tmr_value = POWERUP_TIMER_VAL;
            bsq_pkg::ST_OST: tmr_value = OST_VAL;
            bsq_pkg::ST_PLL: tmr_value = PLL_VAL;
            default: tmr_value = '0;
        endcase
        unique case (state_r)
            bsq_pkg::ST_POWERUP_TIMER: tmr_tick = lfrc_rise;
            bsq_pkg::ST_OST: tmr_tick = osc_rise;
            bsq_pkg::ST_PLL: tmr_tick = 1'b1;
            default: tmr_tick = 1'b0;
        endcase
    end

    bsq_timer u_timer (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_load(tmr_load),
        .i_value(tmr_value),
        .i_tick(tmr_tick),
        .o_done(tmr_done)
    );

    // Core reset ignores the pin in start-up timing; in wake waits and after the end the pin alone sets it
    assign core_rst_nxt = !master_clear_pin_n_s || (state_r != bsq_pkg::ST_DONE &&
        !wake_r);

    // Registered outputs toward the core and the comparator
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_CORE_RST <= 1'b1;
            O_EXEC_HOLD <= 1'b1;
            O_BOR_ACTIVE <= 1'b0;
            O_BOR_VSEL <= 2'h0;
        end else begin
            O_CORE_RST <= core_rst_nxt;
            O_EXEC_HOLD <= core_rst_nxt || state_r != bsq_pkg::ST_DONE;
            O_BOR_ACTIVE <= bor_en;
            O_BOR_VSEL <= I_CFG.bor_voltage_select;
        end
    end

    // Soft brown-out enable: power-on value follows the fuse setting
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            soft_bor_r <= bsq_pkg::SOFT_BOR_RST;
        end else if (por_s) begin
            soft_bor_r <= soft_mode;
        end else if (I_WR && I_ADDR == bsq_pkg::CTRL_OFS && soft_mode) begin
            soft_bor_r <= I_WDATA[bsq_pkg::SOFT_BOR_BIT];
        end
    end

    // Power-on flag: hardware clear beats a software set
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            poweron_flag_r <= bsq_pkg::POWERON_FLAG_RST;
        end else if (por_s) begin
            poweron_flag_r <= 1'b0;
        end else if (I_WR && I_ADDR == bsq_pkg::CTRL_OFS) begin
            poweron_flag_r <= I_WDATA[bsq_pkg::POWERON_FLAG_BIT];
        end
    end

    // Brown-out flag: cleared by trips and power-on, set by software
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            brownout_flag_r <= bsq_pkg::BROWNOUT_FLAG_RST;
        end else if (por_s || bor_trip) begin
            brownout_flag_r <= 1'b0;
        end else if (I_WR && I_ADDR == bsq_pkg::CTRL_OFS) begin
            brownout_flag_r <= I_WDATA[bsq_pkg::BROWNOUT_FLAG_BIT];
        end
    end

    // Read data, valid the cycle after the read strobe only
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
        end else begin
            O_RDATA <= 8'h00;
            if (I_RD && I_ADDR == bsq_pkg::CTRL_OFS) begin
                O_RDATA[bsq_pkg::SOFT_BOR_BIT] <=
                    soft_bor_r && soft_mode;
                O_RDATA[bsq_pkg::POWERON_FLAG_BIT] <= poweron_flag_r;
                O_RDATA[bsq_pkg::BROWNOUT_FLAG_BIT] <= brownout_flag_r;
            end else if (I_RD && I_ADDR == bsq_pkg::STAT_OFS) begin
                O_RDATA[2:0] <= state_r;
                O_RDATA[bsq_pkg::STAT_BOR_BIT] <= bor_en;
                O_RDATA[bsq_pkg::STAT_LOW_BIT] <= low_s;
                O_RDATA[bsq_pkg::STAT_RST_BIT] <= O_CORE_RST;
                O_RDATA[bsq_pkg::STAT_WAKE_BIT] <= wake_r;
            end
        end
    end

    // Checks on the sequence and register behaviour
    property p_bor_hold;
        @(posedge I_CLK) disable iff (I_RST)
        (state_r == bsq_pkg::ST_BOR && low_s) |=>
            (state_r == bsq_pkg::ST_BOR || state_r == bsq_pkg::ST_POR);
    endproperty
    a_bor_hold: assert property (p_bor_hold)
        else $error("brown-out state left while supply low");

    property p_trip;
        @(posedge I_CLK) disable iff (I_RST)
        bor_trip |=> (state_r == bsq_pkg::ST_BOR ||
            state_r == bsq_pkg::ST_POR) ##1 !brownout_flag_r;
    endproperty
    a_trip: assert property (p_trip)
        else $error("brown-out trip did not reset");

    property p_off;
        @(posedge I_CLK) disable iff (I_RST)
        (I_CFG.bor_enable_config == bsq_pkg::BOR_OFF)[*2] |->
            !O_BOR_ACTIVE && !bor_trip;
    endproperty
    a_off: assert property (p_off)
        else $error("brown-out active while disabled");

    property p_soft_read;
        @(posedge I_CLK) disable iff (I_RST)
        (I_RD && I_ADDR == bsq_pkg::CTRL_OFS && !soft_mode) |=>
            !O_RDATA[bsq_pkg::SOFT_BOR_BIT];
    endproperty
    a_soft_read: assert property (p_soft_read)
        else $error("soft enable read nonzero outside soft mode");

    property p_por_flag;
        @(posedge I_CLK) disable iff (I_RST)
        (por_s && !$past(I_RST)) |=> !poweron_flag_r && !brownout_flag_r &&
            soft_bor_r == $past(soft_mode);
    endproperty
    a_por_flag: assert property (p_por_flag)
        else $error("power-on did not clear flags");

    property p_core_rst;
        @(posedge I_CLK) disable iff (I_RST)
        (!master_clear_pin_n_s || (state_r != bsq_pkg::ST_DONE && !wake_r)) |=>
            O_CORE_RST;
    endproperty
    a_core_rst: assert property (p_core_rst)
        else $error("core reset released early");

    property p_no_timeout;
        @(posedge I_CLK) disable iff (I_RST)
        (state_r == bsq_pkg::ST_POR && !por_s && !powerup_timer_en && !xtal &&
            !bor_trip) |=> state_r == bsq_pkg::ST_DONE;
    endproperty
    a_no_timeout: assert property (p_no_timeout)
        else $error("time-out applied without timers");

    property p_powerup_timer_first;
        @(posedge I_CLK) disable iff (I_RST)
        (state_r == bsq_pkg::ST_POR && !por_s && powerup_timer_en && !bor_trip) |=>
            state_r == bsq_pkg::ST_POWERUP_TIMER ##1 !tmr_done;
    endproperty
    a_powerup_timer_first: assert property (p_powerup_timer_first)
        else $error("power-up timer not started after pulse");

    property p_vsel;
        @(posedge I_CLK) disable iff (I_RST)
        !$past(I_RST) |-> O_BOR_VSEL == $past(I_CFG.bor_voltage_select);
    endproperty
    a_vsel: assert property (p_vsel)
        else $error("trip level differs from fuse");

    property p_master_clear_pin_late;
        @(posedge I_CLK) disable iff (I_RST)
        (state_r == bsq_pkg::ST_DONE && master_clear_pin_n_s && !tmr_load) |=>
            !O_CORE_RST;
    endproperty
    a_master_clear_pin_late: assert property (p_master_clear_pin_late)
        else $error("late pin release did not start at once");

endmodule : bsq_sequencer

// >>> verification/bsq_supply_model.sv
// Supply comparator, power-on pulse, clear pin and slow clocks.
// Assumes the bench calls its tasks; both slow clocks run free.
`timescale 1ns/1ps
module bsq_supply_model (
    input wire logic i_clk,
    output logic o_por_pulse,
    output logic o_supply_low,
    output logic o_clear_n,
    output logic o_lfrc_clk,
    output logic o_osc
);
    logic [1:0] ph;
    // Power-on in progress, supply good, pin released at time zero
    initial begin
        ph = 2'h0;
        o_por_pulse = 1'b1;
        o_supply_low = 1'b0;
        o_clear_n = 1'b1;
    end
    // Slow RC and crystal at a quarter of the system rate
    always @(posedge i_clk) begin
        ph <= ph + 2'h1;
    end
    assign o_lfrc_clk = ph[1];
    assign o_osc = ~ph[1];
    // Each level changes just after a rising edge
    task automatic por(input logic v);
        @(posedge i_clk);
        o_por_pulse <= v;
    endtask : por
    task automatic sup(input logic v);
        @(posedge i_clk);
        o_supply_low <= v;
    endtask : sup
    task automatic pin(input logic v);
        @(posedge i_clk);
        o_clear_n <= v;
    endtask : pin
endmodule : bsq_supply_model

// >>> verification/testbench.sv
// Self-checking bench for the reset sequencer.
// Assumes the supply model drives the analog side and slow clocks.
`timescale 1ns/1ps
module testbench;
    localparam int PLL_CYC = 10;
    localparam int SLOW = 4;
    logic clk;
    logic rst;
    bsq_pkg::bsq_cfg_t cfg;
    logic sleep;
    logic pm_exit;
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic por, low, clr_n, lfrc, osc, core_rst, hold, bor_act;
    logic [7:0] rdata;
    logic [1:0] vsel;
    logic [7:0] d;
    int mismatches = 0;
    int total_checks = 0;
    int n;

    always #10 clk = ~clk;

    bsq_supply_model i_model (.i_clk(clk), .o_por_pulse(por),
        .o_supply_low(low), .o_clear_n(clr_n), .o_lfrc_clk(lfrc),
        .o_osc(osc));
    bsq_sequencer #(.P_PLL_LOCK_CYC(PLL_CYC)) i_dut (.I_CLK(clk),
        .I_RST(rst), .I_CFG(cfg), .I_POR_PULSE(por), .I_SUPPLY_LOW(low),
        .I_MASTER_CLEAR_N(clr_n), .I_LFRC_CLK(lfrc), .I_OSC_IN(osc),
        .I_SLEEP(sleep), .I_PM_EXIT(pm_exit), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
        .O_CORE_RST(core_rst), .O_EXEC_HOLD(hold),
        .O_BOR_ACTIVE(bor_act), .O_BOR_VSEL(vsel));

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // Register bus cycles
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask : rd_reg

    // Bounded wait for core reset (0) or execution hold (1) to drop
    task automatic wait_clr(input logic sel);
        n = 0;
        while ((sel ? hold : core_rst) !== 1'b0) begin
            @(posedge clk);
            n++;
            if (n > 20000) begin
                mismatches++;
                results();
            end
        end
    endtask : wait_clr

    // Start-up length expected from the fuses
    function automatic int exp_cyc(input bsq_pkg::bsq_cfg_t c);
        logic x;
        x = c.osc_mode inside {bsq_pkg::OSC_LP, bsq_pkg::OSC_XT,
            bsq_pkg::OSC_HS, bsq_pkg::OSC_HS_CRYSTAL_PLL_MODE};
        exp_cyc = (c.powerup_timer_disable_n ? 0 : bsq_pkg::POWERUP_TIMER_TICKS * SLOW)
            + (x ? bsq_pkg::OST_TICKS * SLOW : 0)
            + (c.osc_mode == bsq_pkg::OSC_HS_CRYSTAL_PLL_MODE ? PLL_CYC : 0);
    endfunction : exp_cyc

    task automatic rng(input int e);
        check(8'(n >= e - 8 && n <= e + 24), 8'h01);
    endtask : rng

    // Fuses, reset, then end of the power-on pulse
    task automatic power_up(input logic [2:0] m, input logic pw_n,
                            input logic [1:0] b);
        @(posedge clk);
        cfg <= '{b, 2'($urandom), pw_n, bsq_pkg::bsq_osc_t'(m)};
        rst <= 1'b1;
        i_model.por(1'b1);
        repeat (8) @(posedge clk);
        check(8'(core_rst), 8'h01);
        rst <= 1'b0;
        i_model.por(1'b0);
    endtask : power_up

    // Main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cfg = '0;
        sleep = 1'b0;
        pm_exit = 1'b0;
        addr = 2'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        void'($urandom(32946));
        for (int m = 0; m < 7; m++) begin
            power_up(3'(m), 1'b1, bsq_pkg::BOR_OFF);
            wait_clr(1'b0);
            rng(exp_cyc(cfg));
            check(8'(vsel), 8'(cfg.bor_voltage_select));
            @(posedge clk);
            pm_exit <= 1'b1;
            @(posedge clk);
            pm_exit <= 1'b0;
            repeat (6) @(posedge clk);
            check(8'(hold), 8'(m < 4));
            check(8'(core_rst), 8'h00);
            wait_clr(1'b1);
        end
        power_up(3'h3, 1'b0, bsq_pkg::BOR_SOFT);
        wait_clr(1'b0);
        rng(exp_cyc(cfg));
        rd_reg(2'h0);
        check(d, 8'h40);
        check(8'(bor_act), 8'h01);
        wr_reg(2'h0, 8'h03);
        repeat (4) @(posedge clk);
        check(8'(bor_act), 8'h00);
        i_model.sup(1'b1);
        repeat (150) @(posedge clk);
        check(8'(core_rst), 8'h00);
        i_model.sup(1'b0);
        wr_reg(2'h0, 8'h43);
        repeat (4) @(posedge clk);
        check(8'(vsel), 8'(cfg.bor_voltage_select));
        i_model.sup(1'b1);
        repeat (60) @(posedge clk);
        i_model.sup(1'b0);
        repeat (6) @(posedge clk);
        check(8'(core_rst), 8'h00);
        i_model.sup(1'b1);
        repeat (150) @(posedge clk);
        check(8'(core_rst), 8'h01);
        repeat (300) @(posedge clk);
        rd_reg(2'h0);
        check(d, 8'h42);
        check(8'(core_rst), 8'h01);
        rd_reg(2'h1);
        check(d, 8'h3c);
        i_model.sup(1'b0);
        repeat (2000) @(posedge clk);
        check(8'(core_rst), 8'h01);
        i_model.sup(1'b1);
        repeat (150) @(posedge clk);
        i_model.sup(1'b0);
        wait_clr(1'b0);
        rng(exp_cyc(cfg));
        wr_reg(2'h2, 8'($urandom));
        rd_reg(2'h2);
        check(d, 8'h00);
        // Time-outs expire while the clear pin is held low
        i_model.pin(1'b0);
        power_up(3'h1, 1'b1, bsq_pkg::BOR_OFF);
        repeat (5000) @(posedge clk);
        check(8'(core_rst), 8'h01);
        i_model.pin(1'b1);
        wait_clr(1'b0);
        check(8'(n <= 4), 8'h01);
        // Fixed brown-out settings in RC mode without power-up timer
        for (int b = 0; b < 4; b++) begin
            if (b != 1) begin
                power_up(3'h5, 1'b1, 2'(b));
                wait_clr(1'b0);
                check(8'(n <= 6), 8'h01);
                wr_reg(2'h0, 8'h40);
                rd_reg(2'h0);
                check(d, 8'h00);
                sleep <= 1'b1;
                repeat (6) @(posedge clk);
                check(8'(bor_act), 8'(b == 3));
                sleep <= 1'b0;
                repeat (6) @(posedge clk);
                check(8'(bor_act), 8'(b != 0));
            end
        end
        i_model.sup(1'b1);
        repeat (150) @(posedge clk);
        check(8'(core_rst), 8'h01);
        i_model.sup(1'b0);
        results();
    end
endmodule : testbench
